// File: rtl/rpie_change_det.sv
`timescale 1ns/1ps
`default_nettype none

module rpie_change_det
   import rpie_pkg::*;
#(
   parameter int W = NUM_PORTS
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset,
   // asynchronous levels
   input  wire logic [W-1:0] level_async,
   // synchronised result
   output logic      [W-1:0] level_sync,
   output logic      [W-1:0] changed
);

   logic [W-1:0]             sync_a;
   logic [W-1:0]             sync_b;
   logic [W-1:0]             prev;
   logic [SYNC_STAGES:0]     primed;
   logic [W-1:0]             next_sync_a;
   logic [W-1:0]             next_sync_b;
   logic [W-1:0]             next_prev;
   logic [SYNC_STAGES:0]     next_primed;

   // ----------------------------------------------------------------
   // two-stage synchroniser and edge detect
   // ----------------------------------------------------------------
   always_comb begin
      next_sync_a = level_async;
      next_sync_b = sync_a;
      next_prev   = sync_b;
      next_primed = {primed[SYNC_STAGES-1:0], 1'b1};
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_a <= '0;
         sync_b <= '0;
         prev   <= '0;
         primed <= '0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         prev   <= next_prev;
         primed <= next_primed;
      end
   end

   // no change reported until the pipe holds real samples
   assign level_sync = sync_b;
   assign changed    = primed[SYNC_STAGES] ? (sync_b ^ prev) : '0;

endmodule

`default_nettype wire

// File: rtl/rpie_pkg.sv
package rpie_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int        NUM_PORTS      = 4;
   localparam int        PORT_IDX_W     = 2;
   localparam int        DDLY_W         = 6;
   localparam int        SYNC_STAGES    = 2;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_SEL       = 8'h4C;
   localparam logic [7:0] ADDR_PORT_STS_ONE   = 8'h4D;
   localparam logic [7:0] ADDR_PORT_STS_TWO   = 8'h4E;
   localparam logic [7:0] ADDR_FILTER_STS_ONE = 8'hD7;
   localparam logic [7:0] ADDR_IRQ_EN_HI      = 8'hD8;
   localparam logic [7:0] ADDR_IRQ_EN_LO      = 8'hD9;
   localparam logic [7:0] ADDR_IRQ_PEND_HI    = 8'hDA;
   localparam logic [7:0] ADDR_IRQ_PEND_LO    = 8'hDB;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_PORT_SEL      = 8'h01;
   localparam logic [7:0] RESET_IRQ_EN        = 8'h00;
   localparam logic [7:0] RESET_READ_DATA     = 8'h00;

   // ----------------------------------------------------------------
   // port select layout
   // ----------------------------------------------------------------
   localparam int        PSEL_WR_LSB    = 0;
   localparam int        PSEL_RD_LSB    = 4;

   // ----------------------------------------------------------------
   // enable / pending bit positions
   // ----------------------------------------------------------------
   localparam logic [7:0] IRQ_EN_HI_MASK = 8'h07;
   localparam logic [7:0] IRQ_EN_LO_MASK = 8'h77;
   localparam int        BIT_ENC        = 2;
   localparam int        BIT_SEQ        = 1;
   localparam int        BIT_CRC        = 0;
   localparam int        BIT_LEN        = 6;
   localparam int        BIT_CNT        = 5;
   localparam int        BIT_BUF        = 4;
   localparam int        BIT_PAR        = 2;
   localparam int        BIT_VALID      = 1;
   localparam int        BIT_LOCK       = 0;

   // pending bits cleared by reading each port status register
   localparam logic [7:0] STS_ONE_CLR_HI = 8'h03;
   localparam logic [7:0] STS_ONE_CLR_LO = 8'h07;
   localparam logic [7:0] STS_TWO_CLR_HI = 8'h04;
   localparam logic [7:0] STS_TWO_CLR_LO = 8'h70;

   // ----------------------------------------------------------------
   // status register layouts
   // ----------------------------------------------------------------
   localparam int        STS1_LOCK      = 0;
   localparam int        STS1_VALID     = 1;
   localparam int        STS1_PAR       = 2;
   localparam int        STS1_CRC       = 3;
   localparam int        STS1_SEQ       = 4;
   localparam int        STS2_ENC       = 0;
   localparam int        STS2_BUF       = 1;
   localparam int        STS2_CNT       = 2;
   localparam int        STS2_LEN       = 3;
   localparam int        FILTER_FAULT_BIT = 6;

endpackage

// File: rtl/rpie_rx_port_irq.sv
// Summary of operation
// - registers banked per port via port select
// - filter fault set on invalid, read clears
// - filter data delay readable, six bits
// - encoding fault interrupts when enabled
// - control channel sequence fault interrupts when enabled
// - control channel checksum fault interrupts when enabled
// - line length change interrupts when enabled
// - line count change interrupts when enabled
// - receive buffer overflow interrupts when enabled
// - parity fault interrupts when enabled
// - port valid change interrupts when enabled
// - lock change interrupts when enabled
// - status register read clears pending events
`timescale 1ns/1ps
`default_nettype none

module rpie_rx_port_irq
   import rpie_pkg::*;
#(
   parameter int NPORT = NUM_PORTS
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   // register access from the control port
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   output logic                       reg_rvalid,
   // event pulses from the receive ports
   input  wire logic [NPORT-1:0]      link_encoding_fault,
   input  wire logic [NPORT-1:0]      ctrl_chan_sequence_fault,
   input  wire logic [NPORT-1:0]      ctrl_chan_checksum_fault,
   input  wire logic [NPORT-1:0]      line_length_change,
   input  wire logic [NPORT-1:0]      line_count_change,
   input  wire logic [NPORT-1:0]      rx_buffer_fault,
   input  wire logic [NPORT-1:0]      link_parity_fault,
   // asynchronous status levels
   input  wire logic [NPORT-1:0]      rx_lock_level,
   input  wire logic [NPORT-1:0]      port_valid_level,
   // filter measurement
   input  wire logic [NPORT-1:0]      filter_measure_invalid,
   input  wire logic [NPORT*DDLY_W-1:0] filter_data_delay_value,
   // interrupt request
   output logic                       irq
);

   logic [7:0]                        port_sel;
   logic [NPORT-1:0][7:0]             irq_en_hi;
   logic [NPORT-1:0][7:0]             irq_en_lo;
   logic [NPORT-1:0][7:0]             pend_hi;
   logic [NPORT-1:0][7:0]             pend_lo;
   logic [NPORT-1:0]                  filter_measure_fault;
   logic [7:0]                        next_port_sel;
   logic [NPORT-1:0][7:0]             next_irq_en_hi;
   logic [NPORT-1:0][7:0]             next_irq_en_lo;
   logic [NPORT-1:0][7:0]             next_pend_hi;
   logic [NPORT-1:0][7:0]             next_pend_lo;
   logic [NPORT-1:0]                  next_filter_measure_fault;
   logic [7:0]                        next_reg_rdata;
   logic                              next_reg_rvalid;
   logic                              next_irq;
   logic [NPORT-1:0]                  lock_change;
   logic [NPORT-1:0]                  valid_change;
   logic [PORT_IDX_W-1:0]             rd_port;
   logic [NPORT-1:0]                  wr_sel;
   logic [NPORT-1:0]                  rd_sel;

   // ----------------------------------------------------------------
   // lock and port valid change detection
   // ----------------------------------------------------------------
   rpie_change_det #(.W(NPORT)) u_lock_det (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .level_async (rx_lock_level),
      .level_sync  (),
      .changed     (lock_change)
   );

   rpie_change_det #(.W(NPORT)) u_valid_det (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .level_async (port_valid_level),
      .level_sync  (),
      .changed     (valid_change)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] pack_sts_one(input logic [7:0] hi, input logic [7:0] lo);
      logic [7:0] v;
      v            = 8'h00;
      v[STS1_LOCK]  = lo[BIT_LOCK];
      v[STS1_VALID] = lo[BIT_VALID];
      v[STS1_PAR]   = lo[BIT_PAR];
      v[STS1_CRC]   = hi[BIT_CRC];
      v[STS1_SEQ]   = hi[BIT_SEQ];
      return v;
   endfunction

   function automatic logic [7:0] pack_sts_two(input logic [7:0] hi, input logic [7:0] lo);
      logic [7:0] v;
      v           = 8'h00;
      v[STS2_ENC] = hi[BIT_ENC];
      v[STS2_BUF] = lo[BIT_BUF];
      v[STS2_CNT] = lo[BIT_CNT];
      v[STS2_LEN] = lo[BIT_LEN];
      return v;
   endfunction

   // port select decode
   always_comb begin
      rd_port = port_sel[PSEL_RD_LSB +: PORT_IDX_W];
      for (int p = 0; p < NPORT; p++) begin
         wr_sel[p] = port_sel[PSEL_WR_LSB + p];
         rd_sel[p] = (rd_port == PORT_IDX_W'(p));
      end
   end

   // ----------------------------------------------------------------
   // register file and event flags
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] ev_hi;
      logic [7:0] ev_lo;
      logic [7:0] clr_hi;
      logic [7:0] clr_lo;
      logic       any;
      ev_hi = 8'h00;
      ev_lo = 8'h00;
      clr_hi = 8'h00;
      clr_lo = 8'h00;
      any = 1'b0;
      next_port_sel = port_sel;
      if (reg_wr && reg_addr == ADDR_PORT_SEL) begin
         next_port_sel = reg_wdata;
      end
      for (int p = 0; p < NPORT; p++) begin
         next_irq_en_hi[p] = irq_en_hi[p];
         next_irq_en_lo[p] = irq_en_lo[p];
         if (reg_wr && wr_sel[p] && reg_addr == ADDR_IRQ_EN_HI) begin
            next_irq_en_hi[p] = reg_wdata & IRQ_EN_HI_MASK;
         end
         if (reg_wr && wr_sel[p] && reg_addr == ADDR_IRQ_EN_LO) begin
            next_irq_en_lo[p] = reg_wdata & IRQ_EN_LO_MASK;
         end
         ev_hi = 8'h00;
         ev_lo = 8'h00;
         ev_hi[BIT_ENC]   = link_encoding_fault[p];
         ev_hi[BIT_SEQ]   = ctrl_chan_sequence_fault[p];
         ev_hi[BIT_CRC]   = ctrl_chan_checksum_fault[p];
         ev_lo[BIT_LEN]   = line_length_change[p];
         ev_lo[BIT_CNT]   = line_count_change[p];
         ev_lo[BIT_BUF]   = rx_buffer_fault[p];
         ev_lo[BIT_PAR]   = link_parity_fault[p];
         ev_lo[BIT_VALID] = valid_change[p];
         ev_lo[BIT_LOCK]  = lock_change[p];
         clr_hi = 8'h00;
         clr_lo = 8'h00;
         if (reg_rd && rd_sel[p] && reg_addr == ADDR_PORT_STS_ONE) begin
            clr_hi = STS_ONE_CLR_HI;
            clr_lo = STS_ONE_CLR_LO;
         end
         if (reg_rd && rd_sel[p] && reg_addr == ADDR_PORT_STS_TWO) begin
            clr_hi = STS_TWO_CLR_HI;
            clr_lo = STS_TWO_CLR_LO;
         end
         // a new event outranks a clear in the same cycle
         next_pend_hi[p] = (pend_hi[p] & ~clr_hi) | ev_hi;
         next_pend_lo[p] = (pend_lo[p] & ~clr_lo) | ev_lo;
         next_filter_measure_fault[p] = filter_measure_invalid[p] |
            (filter_measure_fault[p] & ~(reg_rd && rd_sel[p] && reg_addr == ADDR_FILTER_STS_ONE));
         any = any | (|((pend_hi[p] & irq_en_hi[p]) | (pend_lo[p] & irq_en_lo[p])));
      end
      next_irq = any;
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      next_reg_rvalid = reg_rd;
      next_reg_rdata  = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_PORT_SEL:       next_reg_rdata = port_sel;
            ADDR_PORT_STS_ONE:   next_reg_rdata = pack_sts_one(pend_hi[rd_port], pend_lo[rd_port]);
            ADDR_PORT_STS_TWO:   next_reg_rdata = pack_sts_two(pend_hi[rd_port], pend_lo[rd_port]);
            ADDR_FILTER_STS_ONE: next_reg_rdata = {1'b0, filter_measure_fault[rd_port],
                                                   filter_data_delay_value[rd_port*DDLY_W +: DDLY_W]};
            ADDR_IRQ_EN_HI:      next_reg_rdata = irq_en_hi[rd_port];
            ADDR_IRQ_EN_LO:      next_reg_rdata = irq_en_lo[rd_port];
            ADDR_IRQ_PEND_HI:    next_reg_rdata = pend_hi[rd_port] & irq_en_hi[rd_port];
            ADDR_IRQ_PEND_LO:    next_reg_rdata = pend_lo[rd_port] & irq_en_lo[rd_port];
            default:             next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port_sel             <= RESET_PORT_SEL;
         irq_en_hi            <= '0;
         irq_en_lo            <= '0;
         pend_hi              <= '0;
         pend_lo              <= '0;
         filter_measure_fault <= '0;
         reg_rdata            <= RESET_READ_DATA;
         reg_rvalid           <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         port_sel             <= next_port_sel;
         irq_en_hi            <= next_irq_en_hi;
         irq_en_lo            <= next_irq_en_lo;
         pend_hi              <= next_pend_hi;
         pend_lo              <= next_pend_lo;
         filter_measure_fault <= next_filter_measure_fault;
         reg_rdata            <= next_reg_rdata;
         reg_rvalid           <= next_reg_rvalid;
         irq                  <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic all_en_zero;
   always_comb begin
      all_en_zero = 1'b1;
      for (int p = 0; p < NPORT; p++) begin
         all_en_zero = all_en_zero & ~(|irq_en_hi[p]) & ~(|irq_en_lo[p]);
      end
   end

   for (genvar g = 0; g < NPORT; g++) begin : g_chk
      sequence s_enc_armed;
         link_encoding_fault[g] && irq_en_hi[g][BIT_ENC] && !reg_wr;
      endsequence
      sequence s_quiet;
         !reg_wr && !reg_rd;
      endsequence

      a_filter_set: assert property (@(posedge clk_sys) disable iff (reset)
         filter_measure_invalid[g] |=> filter_measure_fault[g])
         else $error("filter fault not set");
      a_filter_read_clear: assert property (@(posedge clk_sys) disable iff (reset)
         reg_rd && rd_sel[g] && reg_addr == ADDR_FILTER_STS_ONE && !filter_measure_invalid[g]
         |=> !filter_measure_fault[g])
         else $error("filter fault not cleared by read");
      a_enc_irq_raise: assert property (@(posedge clk_sys) disable iff (reset)
         s_enc_armed ##1 s_quiet |=> irq)
         else $error("enabled encoding fault gave no interrupt");
      a_lock_change_flag: assert property (@(posedge clk_sys) disable iff (reset)
         $changed(u_lock_det.sync_b[g]) && u_lock_det.primed[SYNC_STAGES] |=> pend_lo[g][BIT_LOCK])
         else $error("lock change not flagged");
      a_sts_one_clear: assert property (@(posedge clk_sys) disable iff (reset)
         reg_rd && rd_sel[g] && reg_addr == ADDR_PORT_STS_ONE && !link_parity_fault[g]
         && !ctrl_chan_checksum_fault[g] && !ctrl_chan_sequence_fault[g]
         && !lock_change[g] && !valid_change[g]
         |=> ((pend_hi[g] & STS_ONE_CLR_HI) == 8'h00) && ((pend_lo[g] & STS_ONE_CLR_LO) == 8'h00))
         else $error("port status one read left events pending");
      a_sts_two_clear: assert property (@(posedge clk_sys) disable iff (reset)
         reg_rd && rd_sel[g] && reg_addr == ADDR_PORT_STS_TWO && !link_encoding_fault[g]
         && !rx_buffer_fault[g] && !line_count_change[g] && !line_length_change[g]
         |=> ((pend_hi[g] & STS_TWO_CLR_HI) == 8'h00) && ((pend_lo[g] & STS_TWO_CLR_LO) == 8'h00))
         else $error("port status two read left events pending");
      a_seq_fault_flag: assert property (@(posedge clk_sys) disable iff (reset)
         ctrl_chan_sequence_fault[g] |=> pend_hi[g][BIT_SEQ])
         else $error("sequence fault not flagged");
      a_crc_fault_flag: assert property (@(posedge clk_sys) disable iff (reset)
         ctrl_chan_checksum_fault[g] |=> pend_hi[g][BIT_CRC])
         else $error("checksum fault not flagged");
      a_len_change_flag: assert property (@(posedge clk_sys) disable iff (reset)
         line_length_change[g] |=> pend_lo[g][BIT_LEN])
         else $error("line length change not flagged");
      a_cnt_change_flag: assert property (@(posedge clk_sys) disable iff (reset)
         line_count_change[g] |=> pend_lo[g][BIT_CNT])
         else $error("line count change not flagged");
      a_buf_fault_flag: assert property (@(posedge clk_sys) disable iff (reset)
         rx_buffer_fault[g] |=> pend_lo[g][BIT_BUF])
         else $error("buffer fault not flagged");
      a_par_fault_flag: assert property (@(posedge clk_sys) disable iff (reset)
         link_parity_fault[g] |=> pend_lo[g][BIT_PAR])
         else $error("parity fault not flagged");
      a_valid_change_flag: assert property (@(posedge clk_sys) disable iff (reset)
         $changed(u_valid_det.sync_b[g]) && u_valid_det.primed[SYNC_STAGES] |=> pend_lo[g][BIT_VALID])
         else $error("port valid change not flagged");
   end

   a_enable_write_masked: assert property (@(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == ADDR_IRQ_EN_LO && wr_sel[0]
      |=> irq_en_lo[0] == ($past(reg_wdata) & IRQ_EN_LO_MASK))
      else $error("enable write not stored with reserved bits cleared");
   a_irq_off_disabled: assert property (@(posedge clk_sys) disable iff (reset)
      all_en_zero |=> !irq)
      else $error("interrupt raised with all enables off");
   a_read_answer: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == ADDR_IRQ_EN_HI |=> reg_rvalid && reg_rdata == irq_en_hi[$past(rd_port)])
      else $error("read of enable register gave wrong port data");

endmodule

`default_nettype wire

// File: verif/rpie_host.sv
`timescale 1ns/1ps
`default_nettype none

module rpie_host (
   // clock
   input  wire logic       clk_sys,
   // register bus
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // ----------------------------------------------------------------
   // one write, taken at the second edge
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   // ----------------------------------------------------------------
   // one read, answer taken at the edge after the strobe is taken
   // ----------------------------------------------------------------
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      // answer stands one cycle: sample before this edge updates it
      @(posedge clk_sys);
      d  = reg_rdata;
      ok = reg_rvalid;
   endtask
endmodule

`default_nettype wire

// File: verif/rpie_rx_port_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module rpie_rx_port_irq_tb;
   import rpie_pkg::*;

   logic                          clk_sys;
   logic                          reset;
   logic                          reg_wr;
   logic                          reg_rd;
   logic [7:0]                    reg_addr;
   logic [7:0]                    reg_wdata;
   logic [7:0]                    reg_rdata;
   logic                          reg_rvalid;
   logic [6:0][NUM_PORTS-1:0]     ev;
   logic [NUM_PORTS-1:0]          lock_lvl;
   logic [NUM_PORTS-1:0]          valid_lvl;
   logic [NUM_PORTS-1:0]          flt_inv;
   logic [NUM_PORTS*DDLY_W-1:0]   ddly;
   logic                          irq;
   int                            fails;
   int                            checked;
   // status register clearing each event: enc seq crc len cnt buf par
   logic [7:0]                    sta [7];
   // status read value and pending value each event leaves
   logic [7:0]                    stv [7];
   logic [7:0]                    pnd [7];

   initial begin
      clk_sys   = 1'b0;
      reset     = 1'b1;
      ev        = '0;
      lock_lvl  = '0;
      valid_lvl = '0;
      flt_inv   = '0;
      ddly      = {6'h3F, 6'h2A, 6'h15, 6'h01};
      fails     = 0;
      checked   = 0;
      sta       = '{ADDR_PORT_STS_TWO, ADDR_PORT_STS_ONE, ADDR_PORT_STS_ONE, ADDR_PORT_STS_TWO,
                    ADDR_PORT_STS_TWO, ADDR_PORT_STS_TWO, ADDR_PORT_STS_ONE};
      stv       = '{8'h01, 8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h04};
      pnd       = '{8'h04, 8'h02, 8'h01, 8'h40, 8'h20, 8'h10, 8'h04};
   end

   always #2 clk_sys = ~clk_sys;

   rpie_host host (
      .clk_sys    (clk_sys),
      .reg_wr     (reg_wr),
      .reg_rd     (reg_rd),
      .reg_addr   (reg_addr),
      .reg_wdata  (reg_wdata),
      .reg_rdata  (reg_rdata),
      .reg_rvalid (reg_rvalid)
   );

   rpie_rx_port_irq DUT (
      .clk_sys                  (clk_sys),
      .reset                    (reset),
      .reg_wr                   (reg_wr),
      .reg_rd                   (reg_rd),
      .reg_addr                 (reg_addr),
      .reg_wdata                (reg_wdata),
      .reg_rdata                (reg_rdata),
      .reg_rvalid               (reg_rvalid),
      .link_encoding_fault      (ev[0]),
      .ctrl_chan_sequence_fault (ev[1]),
      .ctrl_chan_checksum_fault (ev[2]),
      .line_length_change       (ev[3]),
      .line_count_change        (ev[4]),
      .rx_buffer_fault          (ev[5]),
      .link_parity_fault        (ev[6]),
      .rx_lock_level            (lock_lvl),
      .port_valid_level         (valid_lvl),
      .filter_measure_invalid   (flt_inv),
      .filter_data_delay_value  (ddly),
      .irq                      (irq)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, e)
   endtask

   task automatic pulse(input int k, input int p);
      @(posedge clk_sys);
      ev[k][p] <= 1'b1;
      @(posedge clk_sys);
      ev       <= '0;
      #1;
   endtask

   task automatic clr_check(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, e)
      @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0)
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      `CHK(irq, 1'b0)
      rdc(ADDR_PORT_SEL, RESET_PORT_SEL);
      rdc(ADDR_IRQ_EN_HI, 8'h00);
      rdc(ADDR_IRQ_EN_LO, 8'h00);
      rdc(ADDR_FILTER_STS_ONE, 8'h01);
      rdc(8'h00, 8'h00);
   endtask

   task automatic t_masked;
      pulse(0, 0);
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0)
      clr_check(ADDR_PORT_STS_TWO, 8'h01);
   endtask

   task automatic t_regs;
      host.wr(ADDR_IRQ_EN_HI, 8'hFF);
      host.wr(ADDR_IRQ_EN_LO, 8'hFF);
      rdc(ADDR_IRQ_EN_HI, 8'h07);
      rdc(ADDR_IRQ_EN_LO, 8'h77);
      host.wr(ADDR_PORT_SEL, 8'h12);
      rdc(ADDR_IRQ_EN_HI, 8'h00);
      rdc(ADDR_IRQ_EN_LO, 8'h00);
      host.wr(ADDR_PORT_SEL, 8'h01);
   endtask

   task automatic t_events;
      for (int k = 0; k < 7; k++) begin
         pulse(k, 0);
         `CHK(irq, 1'b0)
         @(posedge clk_sys);
         #1;
         `CHK(irq, 1'b1)
         rdc((k < 3) ? ADDR_IRQ_PEND_HI : ADDR_IRQ_PEND_LO, pnd[k]);
         clr_check(sta[k], stv[k]);
      end
   endtask

   task automatic t_lockvalid;
      host.wr(ADDR_PORT_SEL, 8'h38);
      host.wr(ADDR_IRQ_EN_LO, 8'h03);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_sys);
         if (j < 2) begin
            lock_lvl[3] <= ~lock_lvl[3];
         end else begin
            valid_lvl[3] <= ~valid_lvl[3];
         end
         for (int n = 0; n < 12 && irq !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
         end
         `CHK(irq, 1'b1)
         clr_check(ADDR_PORT_STS_ONE, (j < 2) ? 8'h01 : 8'h02);
      end
   endtask

   task automatic t_filter;
      host.wr(ADDR_PORT_SEL, 8'h12);
      @(posedge clk_sys);
      flt_inv[1] <= 1'b1;
      @(posedge clk_sys);
      flt_inv    <= '0;
      rdc(ADDR_FILTER_STS_ONE, 8'h55);
      rdc(ADDR_FILTER_STS_ONE, 8'h15);
      host.wr(ADDR_FILTER_STS_ONE, 8'hFF);
      @(posedge clk_sys);
      ddly[11:6] <= 6'h2B;
      rdc(ADDR_FILTER_STS_ONE, 8'h2B);
   endtask

   // ----------------------------------------------------------------
   // verdict
   // ----------------------------------------------------------------
   task automatic results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #20000;
      fails++;
      results();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_masked();
      t_regs();
      t_events();
      t_lockvalid();
      t_filter();
      results();
   end
endmodule

`default_nettype wire
